// file: dv/scl_otp_model.sv
`timescale 1ns/1ns
module scl_otp_model (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic        otp_rd,
	input  wire logic [13:0] otp_addr,
	input  wire logic        eep_req,
	input  wire logic [6:0]  eep_addr,
	input  wire logic [3:0]  lat,
	input  wire logic [6:0]  ack_addr,
	output logic             otp_ack,
	output logic [15:0]      otp_rdata,
	output logic             eep_ack,
	output logic             eep_nak
);
	// Whole store as 16 K words, filled by the bench
	logic [15:0] mem [0:16383];
	int          ocnt;
	int          ecnt;

	// One read in flight; data is scrambled outside the ack cycle
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			ocnt      <= 0;
			ecnt      <= 0;
			otp_ack   <= 1'b0;
			otp_rdata <= 16'h0000;
			eep_ack   <= 1'b0;
			eep_nak   <= 1'b0;
		end
		else
		begin
			otp_ack   <= 1'b0;
			otp_rdata <= ~otp_rdata;
			eep_ack   <= 1'b0;
			eep_nak   <= 1'b0;
			if (otp_rd)
				ocnt <= int'(lat);
			else if (ocnt == 1)
			begin
				otp_ack   <= 1'b1;
				otp_rdata <= mem[otp_addr];
				ocnt      <= 0;
			end
			else if (ocnt > 1)
				ocnt <= ocnt - 1;
			// Only the chosen address acks; every other address answers with a nak
			if (eep_req)
				ecnt <= 2;
			else if (ecnt == 1)
			begin
				eep_ack <= (eep_addr == ack_addr);
				eep_nak <= (eep_addr != ack_addr);
				ecnt    <= 0;
			end
			else if (ecnt > 1)
				ecnt <= ecnt - 1;
		end
	end
endmodule

// file: dv/tb_reset_strap_otp_config_loader.sv
`timescale 1ns/1ns
module tb_reset_strap_otp_config_loader;
	typedef struct {
		logic [15:0] hdr;
		logic [15:0] f1;
		logic [15:0] f2;
		logic [15:0] strap;
		logic [6:0]  ack;
		logic [15:0] idx;
		logic [3:0]  out;
		logic [2:0]  err;
		logic [1:0]  nwr;
	} scl_tb_row_t;

	logic        mclk, rstn = 0, otp_ack, otp_rd, reg_clear, reg_wr, host_wr = 0;
	logic        proto_i2c, addr_a2, eeprom_en, cfg_loaded, strap_fault, load_done;
	logic        eep_ack, eep_nak, eep_req;
	logic [15:0] strap = 16'hffff, otp_rdata, host_addr = 0, host_wdata = 0;
	logic [15:0] reg_addr, reg_wdata, cfg_index, last_wa, last_wd;
	logic [13:0] otp_addr, first_a;
	logic [6:0]  eep_addr, ack_addr = 0;
	logic [3:0]  lat = 1;
	logic [2:0]  cfg_error;
	logic [1:0]  eep_speed;
	int          bad_count = 0, check_count = 0, n_wr = 0, n_clr = 0, n_rd = 0, n_req = 0;
	int          early = 0;
	scl_tb_row_t rows [12];

	scl_loader dut (.mclk(mclk), .rstn(rstn), .gpio_strap(strap), .otp_ack(otp_ack),
		.otp_rdata(otp_rdata), .host_wr(host_wr), .host_addr(host_addr),
		.host_wdata(host_wdata), .eep_ack(eep_ack), .eep_nak(eep_nak), .otp_rd(otp_rd),
		.otp_addr(otp_addr), .reg_clear(reg_clear), .reg_wr(reg_wr), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .proto_i2c(proto_i2c), .addr_a2(addr_a2),
		.eeprom_en(eeprom_en), .cfg_index(cfg_index), .cfg_loaded(cfg_loaded),
		.cfg_error(cfg_error), .strap_fault(strap_fault), .load_done(load_done),
		.eep_req(eep_req), .eep_addr(eep_addr), .eep_speed(eep_speed));

	scl_otp_model otp (.mclk(mclk), .rstn(rstn), .otp_rd(otp_rd), .otp_addr(otp_addr),
		.eep_req(eep_req), .eep_addr(eep_addr), .lat(lat), .ack_addr(ack_addr),
		.otp_ack(otp_ack), .otp_rdata(otp_rdata), .eep_ack(eep_ack), .eep_nak(eep_nak));

	// Free-running system clock, 50 ns period
	initial
	begin
		mclk = 0;
		forever #25 mclk = ~mclk;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Tally load traffic per run; counters restart with every reset
	always @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
		begin
			n_wr = 0;
			n_clr = 0;
			n_rd = 0;
			n_req = 0;
			early = 0;
			first_a = 14'h3fff;
		end
		else
		begin
			if ((otp_rd || reg_wr) && n_clr == 0)
				early = 1;
			if (reg_wr)
			begin
				n_wr++;
				last_wa = reg_addr;
				last_wd = reg_wdata;
			end
			if (otp_rd && n_rd++ == 0)
				first_a = otp_addr;
			if (reg_clear)
				n_clr++;
			if (eep_req)
			begin
				check("probe addr", eep_addr, 7'h50 + n_req % 8);
				check("probe speed", eep_speed, n_req / 8);
				n_req++;
			end
		end
	end

	// Stored configuration with a correct or spoiled checksum
	task automatic put_cfg(input int base, input logic [15:0] h, input logic [15:0] bad);
		logic [15:0] s;
		s = h + 16'h0100 + 16'h1234 + 16'h0200 + 16'h00ab;
		otp.mem[base] = h;
		otp.mem[base+1] = 16'h0100;
		otp.mem[base+2] = 16'h1234;
		otp.mem[base+3] = 16'h0200;
		otp.mem[base+4] = 16'h00ab;
		otp.mem[base+5] = 16'h0000 - s + bad;
	endtask

	// Straps are held through reset, then turned round once captured
	task automatic run(input scl_tb_row_t r, input logic [3:0] l);
		int k;
		otp.mem[0] = r.hdr;
		otp.mem[1] = r.f1;
		otp.mem[2] = r.f2;
		strap = r.strap;
		ack_addr = r.ack;
		lat = l;
		rstn = 0;
		repeat (3) @(negedge mclk);
		check("quiet in reset", {otp_rd, reg_wr, load_done}, 0);
		rstn = 1;
		repeat (4) @(negedge mclk);
		strap = ~r.strap;
		k = 0;
		while (load_done !== 1'b1 && k < 3000)
		begin
			@(negedge mclk);
			k++;
		end
		check("done in time", k < 3000, 1);
		if (k >= 3000)
			complete_run();
	endtask

	initial
	begin
		for (int i = 0; i < 16; i++)
			otp.mem[16+i] = 16'h0000;
		otp.mem[16+15] = 16'h0040;
		otp.mem[16+3] = 16'h0050;
		otp.mem[16+5] = 16'h0060;
		put_cfg(16'h0040, 16'h8002, 16'h0000);
		put_cfg(16'h0050, 16'h8002, 16'h0001);
		put_cfg(16'h0060, 16'h0002, 16'h0000);
		// Configuration 14 rewrites the serial setup register: I2C with A2 set
		otp.mem[16+14] = 16'h0070;
		otp.mem[16'h70] = 16'h8001;
		otp.mem[16'h71] = 16'h0010;
		otp.mem[16'h72] = 16'h0003;
		otp.mem[16'h73] = 16'h7fec;
		rows = '{
			'{16'hc000, 16'h0000, 16'h0000, 16'hffff, 7'h00, 16'h000f, 4'hb, 3'h0, 2'h2},
			'{16'hc000, 16'h0000, 16'h0020, 16'hfdf3, 7'h00, 16'h0003, 4'h0, 3'h2, 2'h0},
			'{16'hc000, 16'h1400, 16'h0120, 16'hffbf, 7'h00, 16'h0005, 4'h8, 3'h3, 2'h0},
			'{16'hc000, 16'hcc00, 16'h0020, 16'hff7f, 7'h00, 16'h000f, 4'h9, 3'h0, 2'h2},
			'{16'hc000, 16'hcc00, 16'h0020, 16'hffdf, 7'h00, 16'h000f, 4'hd, 3'h0, 2'h2},
			'{16'hc000, 16'hcc00, 16'h0020, 16'hfdff, 7'h00, 16'h000f, 4'h1, 3'h0, 2'h2},
			'{16'hc000, 16'h0155, 16'h0020, 16'hfff0, 7'h00, 16'h0010, 4'h8, 3'h1, 2'h0},
			'{16'h8000, 16'h0000, 16'h0000, 16'hffff, 7'h53, 16'h000f, 4'ha, 3'h1, 2'h0},
			'{16'h4000, 16'h0000, 16'h0000, 16'hffff, 7'h50, 16'h000f, 4'ha, 3'h5, 2'h0},
			'{16'h8000, 16'h0000, 16'h0000, 16'hffff, 7'h00, 16'h000f, 4'ha, 3'h4, 2'h0},
			'{16'hc000, 16'h0000, 16'h0000, 16'hfeff, 7'h00, 16'h000f, 4'hb, 3'h0, 2'h2},
			'{16'hc000, 16'h0000, 16'h0000, 16'hfdfe, 7'h00, 16'h000e, 4'hf, 3'h0, 2'h1}};
		// Ordinary start-up cases, prompt and slow memory in turn
		for (int i = 0; i < 10; i++)
		begin
			run(rows[i], 4'(1 + i % 3));
			check("index", cfg_index, rows[i].idx);
			check("flags", {proto_i2c, addr_a2, eeprom_en, cfg_loaded}, rows[i].out);
			check("error", cfg_error, rows[i].err);
			check("writes", n_wr, rows[i].nwr);
			if (rows[i].nwr != 0)
				check("last write", {last_wa, last_wd}, 32'h020000ab);
			check("clears", n_clr, 1);
			check("clear first", early, 0);
			check("info first", first_a, 0);
			check("no fault", strap_fault, 0);
			$display("row %0d done", i);
		end
		check("probe count", n_req, 24);
		// Board lets pin 8 drop during reset
		run(rows[10], 4'h2);
		check("fault", strap_fault, 1);
		$display("strap fault test done");
		// Serial writes to the setup register after start-up
		run(rows[0], 4'h1);
		for (int d = 1; d < 4; d++)
		begin
			host_wr = 1;
			host_addr = 16'h0010;
			host_wdata = 16'(d);
			@(negedge mclk);
			host_wr = 0;
			@(negedge mclk);
			check("snoop", {proto_i2c, addr_a2}, {d[0], d[0] & d[1]});
		end
		$display("serial override test done");
		// SPI strap, then stored data switches the port to I2C with A2
		run(rows[11], 4'h3);
		check("cfg index", cfg_index, rows[11].idx);
		check("cfg override", {proto_i2c, addr_a2, eeprom_en, cfg_loaded}, rows[11].out);
		check("cfg writes", n_wr, rows[11].nwr);
		check("cfg write", {last_wa, last_wd}, 32'h00100003);
		$display("stored override test done");
		complete_run();
	end
endmodule

// file: include/scl_pkg.sv
package scl_pkg;

	// Strap pins and word sizes
	localparam int GPIO_N   = 16;
	localparam int DW       = 16;
	localparam int OTP_AW   = 14;
	localparam int PIN_PROTO = 9;
	localparam int PIN_HOLD  = 8;
	localparam int SEL_DEF_W = 4;
	localparam int CFG_MAX   = 16;

	// Synchroniser depth and the wait before straps are taken
	localparam logic [1:0] SYNC_CYC = 2'h2;

	// Storage layout of the one-time memory, in 16-bit words
	localparam logic [13:0] INFO_HDR_ADDR = 14'h0000;
	localparam logic [13:0] INFO_FN_LO    = 14'h0001;
	localparam logic [13:0] INFO_FN_HI    = 14'h0002;
	localparam logic [13:0] DIR_BASE      = 14'h0010;
	localparam int HDR_VALID_BIT = 15;
	localparam int HDR_PROG_BIT  = 14;
	localparam int HDR_CNT_W     = 12;

	// Serial port setup register snooped on the register write path
	localparam logic [15:0] SER_CFG_ADDR = 16'h0010;
	localparam int SER_I2C_BIT = 0;
	localparam int SER_A2_BIT  = 1;

	// Result codes
	localparam logic [2:0] ERR_NONE  = 3'h0;
	localparam logic [2:0] ERR_NOCFG = 3'h1;
	localparam logic [2:0] ERR_SUM   = 3'h2;
	localparam logic [2:0] ERR_INVAL = 3'h3;
	localparam logic [2:0] ERR_NOEEP = 3'h4;
	localparam logic [2:0] ERR_INFO  = 3'h5;

	// External memory probe range
	localparam logic [6:0] EEP_ADDR_FIRST = 7'h50;
	localparam logic [6:0] EEP_ADDR_LAST  = 7'h57;

	typedef enum logic [1:0] {
		FN_NONE   = 2'b00,
		FN_CFGSEL = 2'b01,
		FN_EEDIS  = 2'b10,
		FN_ADDRA2 = 2'b11
	} scl_fn_t;

	typedef enum logic [1:0] {
		SPD_1M   = 2'b00,
		SPD_400K = 2'b01,
		SPD_100K = 2'b10
	} scl_spd_t;

	typedef enum logic [3:0] {
		ST_SYNC    = 4'b0000,
		ST_DEFAULT = 4'b0001,
		ST_INFO    = 4'b0010,
		ST_DECODE  = 4'b0011,
		ST_DIR     = 4'b0100,
		ST_HDR     = 4'b0101,
		ST_SUM     = 4'b0110,
		ST_WADDR   = 4'b0111,
		ST_WDATA   = 4'b1000,
		ST_EEP     = 4'b1001,
		ST_DONE    = 4'b1010
	} scl_st_t;

endpackage

// file: include/scl_prb_if.sv
`timescale 1ns/1ns
interface scl_prb_if;
	logic                start;
	logic                done;
	logic                found;
	logic                req;
	logic                ack;
	logic                nak;
	logic [6:0]          addr;
	scl_pkg::scl_spd_t   speed;

	modport ldr (output start, ack, nak, input done, found, req, addr, speed);
	modport prb (input start, ack, nak, output done, found, req, addr, speed);
endinterface

// file: verilog/scl_loader.sv
`timescale 1ns/1ns
// Notes on behaviour
// - Latched pin 9 picks the serial protocol: low SPI, high I2C.
// - Strap levels are captured at reset release and used for all decisions.
// - No pin assigned to address bit A2 gives A2 of zero.
// - Several A2 pins: only the highest indexed one counts.
// - A2 strap is ignored when the port runs SPI.
// - Any high disable pin skips all external memory access; else try it.
// - No selection pins assigned: pins 3..0 form the index.
// - With no selection pins assigned, all straps pulled up select stored configuration 15.
// - Selection pins form the index lowest pin LSB upward.
// - Fewer than four pins zero-extend; more make a wider index.
// - Unprogrammed parts: selection straps change nothing that is loaded.
// - Defaults leave clock outputs off and all pins as inputs.
// - Registers go to defaults first, stored contents afterwards.
// - The device information block is always loaded.
// - The index picks one of up to sixteen stored configurations.
// - Only the stored registers are written; others keep defaults.
// - A configuration failing its checksum is not loaded at all.
// - Blocks marked invalid are skipped.
// - Serial port writes are never stored back into one-time memory.
// - One-time memory holds 32 kilobytes in singly programmable blocks.
// - Loaded data or serial writes may override strap port setup.
// - Probe external memory at addresses 50h..57h at 1M, 400k, 100k.
// - Missing or bad configuration falls through to the external search.
module scl_loader (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [15:0] gpio_strap,
	input  wire logic        otp_ack,
	input  wire logic [15:0] otp_rdata,
	input  wire logic        host_wr,
	input  wire logic [15:0] host_addr,
	input  wire logic [15:0] host_wdata,
	input  wire logic        eep_ack,
	input  wire logic        eep_nak,
	output logic             otp_rd,
	output logic [13:0]      otp_addr,
	output logic             reg_clear,
	output logic             reg_wr,
	output logic [15:0]      reg_addr,
	output logic [15:0]      reg_wdata,
	output logic             proto_i2c,
	output logic             addr_a2,
	output logic             eeprom_en,
	output logic [15:0]      cfg_index,
	output logic             cfg_loaded,
	output logic [2:0]       cfg_error,
	output logic             strap_fault,
	output logic             load_done,
	output logic             eep_req,
	output logic [6:0]       eep_addr,
	output logic [1:0]       eep_speed
);
	typedef struct packed {
		scl_pkg::scl_st_t st;
		logic             rd_pend;
		logic [1:0]       wait_cnt;
		logic [15:0]      straps;
		logic             prog;
		logic [31:0]      fn;
		logic [13:0]      ptr;
		logic [13:0]      base;
		logic [12:0]      cnt;
		logic [11:0]      pairs;
		logic [15:0]      sum;
		logic             probe_busy;
		logic             probe_start;
		logic             otp_rd;
		logic [13:0]      otp_addr;
		logic             reg_clear;
		logic             reg_wr;
		logic [15:0]      reg_addr;
		logic [15:0]      reg_wdata;
		logic             proto_i2c;
		logic             addr_a2;
		logic             eeprom_en;
		logic [15:0]      cfg_index;
		logic             cfg_loaded;
		logic [2:0]       cfg_error;
		logic             strap_fault;
		logic             load_done;
		logic             seen_clear;   // Watch-only: the default pulse has happened
	} scl_ldr_state_t;

	scl_ldr_state_t s;
	scl_ldr_state_t next_s;
	logic [15:0]    straps_sync;

	scl_prb_if prb ();

	// Pins are asynchronous to mclk, so two stages before anything looks
	scl_sync u_sync (
		.mclk (mclk),
		.rstn (rstn),
		.din  (gpio_strap),
		.dout (straps_sync)
	);

	scl_probe u_probe (
		.mclk (mclk),
		.rstn (rstn),
		.p    (prb.prb)
	);

	assign prb.start = s.probe_start;
	assign prb.ack   = eep_ack;
	assign prb.nak   = eep_nak;

	// Function code of one pin from the information block
	function automatic scl_pkg::scl_fn_t scl_fn_of(input logic [31:0] fn, input int i);
		return scl_pkg::scl_fn_t'(fn[2*i +: 2]);
	endfunction

	// Setup register decode, shared by stored data and serial writes
	function automatic logic [1:0] scl_ser_cfg(input logic [15:0] d);
		return {d[scl_pkg::SER_I2C_BIT] & d[scl_pkg::SER_A2_BIT], d[scl_pkg::SER_I2C_BIT]};
	endfunction

	// Sequencer: capture, defaults, info block, selected configuration, probe
	always_comb
	begin
		logic              got;
		logic              sel_any;
		logic              a2_hit;
		logic              a2_val;
		logic              ee_dis;
		logic [15:0]       idx;
		logic [15:0]       nsum;
		logic [1:0]        ser;
		int                k;
		scl_pkg::scl_st_t  fail_st;
		got     = s.rd_pend && otp_ack;
		sel_any = 1'b0;
		a2_hit  = 1'b0;
		a2_val  = 1'b0;
		ee_dis  = 1'b0;
		idx     = 16'h0000;
		nsum    = s.sum + otp_rdata;
		ser     = scl_ser_cfg((s.st == scl_pkg::ST_DONE) ? host_wdata : otp_rdata);
		k       = 0;
		fail_st = s.eeprom_en ? scl_pkg::ST_EEP : scl_pkg::ST_DONE;

		// Later A2 pins overwrite earlier ones, so the highest index wins
		for (int i = 0; i < scl_pkg::GPIO_N; i++)
		begin
			if (scl_fn_of(s.fn, i) == scl_pkg::FN_CFGSEL)
			begin
				idx[k[3:0]] = s.straps[i];
				k           = k + 1;
				sel_any     = 1'b1;
			end
			if (scl_fn_of(s.fn, i) == scl_pkg::FN_ADDRA2)
			begin
				a2_hit = 1'b1;
				a2_val = s.straps[i];
			end
			if (scl_fn_of(s.fn, i) == scl_pkg::FN_EEDIS && s.straps[i])
				ee_dis = 1'b1;
		end
		if (!sel_any)
			idx = {12'h000, s.straps[scl_pkg::SEL_DEF_W-1:0]};

		next_s             = s;
		next_s.otp_rd      = 1'b0;
		next_s.reg_clear   = 1'b0;
		next_s.reg_wr      = 1'b0;
		next_s.probe_start = 1'b0;
		next_s.seen_clear  = s.seen_clear | s.reg_clear;

		// Read engine: one request outstanding, pointer advances per word
		if (s.st inside {scl_pkg::ST_INFO, scl_pkg::ST_DIR, scl_pkg::ST_HDR,
			scl_pkg::ST_SUM, scl_pkg::ST_WADDR, scl_pkg::ST_WDATA} && !s.rd_pend)
		begin
			next_s.otp_rd   = 1'b1;
			next_s.rd_pend  = 1'b1;
			next_s.otp_addr = s.ptr;
		end
		if (got)
		begin
			next_s.rd_pend = 1'b0;
			next_s.ptr     = s.ptr + 14'h0001;
		end

		unique case (s.st)
			scl_pkg::ST_SYNC:
			begin
				// The synchroniser needs two edges after release to show the pins
				next_s.wait_cnt = s.wait_cnt + 2'h1;
				if (s.wait_cnt == scl_pkg::SYNC_CYC)
				begin
					next_s.straps      = straps_sync;
					next_s.strap_fault = !straps_sync[scl_pkg::PIN_HOLD];
					next_s.proto_i2c   = straps_sync[scl_pkg::PIN_PROTO];
					next_s.st          = scl_pkg::ST_DEFAULT;
				end
			end
			scl_pkg::ST_DEFAULT:
			begin
				next_s.reg_clear = 1'b1;
				next_s.ptr       = scl_pkg::INFO_HDR_ADDR;
				next_s.st        = scl_pkg::ST_INFO;
			end
			scl_pkg::ST_INFO:
			begin
				if (got)
				begin
					unique case (s.ptr)
						scl_pkg::INFO_HDR_ADDR:
						begin
							next_s.prog = otp_rdata[scl_pkg::HDR_PROG_BIT];
							// An invalidated block leaves every pin unassigned
							if (!otp_rdata[scl_pkg::HDR_VALID_BIT])
							begin
								next_s.prog      = 1'b0;
								next_s.cfg_error = scl_pkg::ERR_INFO;
								next_s.st        = scl_pkg::ST_DECODE;
							end
						end
						scl_pkg::INFO_FN_LO:
							next_s.fn[15:0] = otp_rdata;
						default:
						begin
							next_s.fn[31:16] = otp_rdata;
							next_s.st        = scl_pkg::ST_DECODE;
						end
					endcase
				end
			end
			scl_pkg::ST_DECODE:
			begin
				next_s.addr_a2   = s.proto_i2c && a2_hit && a2_val;
				next_s.eeprom_en = !ee_dis;
				next_s.cfg_index = idx;
				next_s.ptr       = scl_pkg::DIR_BASE + {10'h000, idx[3:0]};
				if (!s.prog)
				begin
					// Straps select nothing when no configuration exists
					if (s.cfg_error == scl_pkg::ERR_NONE)
						next_s.cfg_error = scl_pkg::ERR_NOCFG;
					next_s.st = ee_dis ? scl_pkg::ST_DONE : scl_pkg::ST_EEP;
				end
				else if (idx >= 16'(scl_pkg::CFG_MAX))
				begin
					next_s.cfg_error = scl_pkg::ERR_NOCFG;
					next_s.st        = ee_dis ? scl_pkg::ST_DONE : scl_pkg::ST_EEP;
				end
				else
					next_s.st = scl_pkg::ST_DIR;
			end
			scl_pkg::ST_DIR:
			begin
				if (got)
				begin
					if (otp_rdata == 16'h0000)
					begin
						next_s.cfg_error = scl_pkg::ERR_NOCFG;
						next_s.st        = fail_st;
					end
					else
					begin
						next_s.ptr = otp_rdata[13:0];
						next_s.st  = scl_pkg::ST_HDR;
					end
				end
			end
			scl_pkg::ST_HDR:
			begin
				if (got)
				begin
					if (!otp_rdata[scl_pkg::HDR_VALID_BIT])
					begin
						next_s.cfg_error = scl_pkg::ERR_INVAL;
						next_s.st        = fail_st;
					end
					else
					begin
						next_s.pairs = otp_rdata[scl_pkg::HDR_CNT_W-1:0];
						next_s.cnt   = {otp_rdata[scl_pkg::HDR_CNT_W-1:0], 1'b1};
						next_s.sum   = otp_rdata;
						next_s.base  = s.ptr + 14'h0001;
						next_s.st    = scl_pkg::ST_SUM;
					end
				end
			end
			scl_pkg::ST_SUM:
			begin
				// First pass only checks, so a bad block never touches a register
				if (got)
				begin
					next_s.sum = nsum;
					next_s.cnt = s.cnt - 13'h0001;
					if (s.cnt == 13'h0001)
					begin
						next_s.ptr = s.base;
						if (nsum != 16'h0000)
						begin
							next_s.cfg_error = scl_pkg::ERR_SUM;
							next_s.st        = fail_st;
						end
						else if (s.pairs == 12'h000)
						begin
							next_s.cfg_loaded = 1'b1;
							next_s.st         = scl_pkg::ST_DONE;
						end
						else
							next_s.st = scl_pkg::ST_WADDR;
					end
				end
			end
			scl_pkg::ST_WADDR:
			begin
				if (got)
				begin
					next_s.reg_addr = otp_rdata;
					next_s.st       = scl_pkg::ST_WDATA;
				end
			end
			scl_pkg::ST_WDATA:
			begin
				if (got)
				begin
					next_s.reg_wr    = 1'b1;
					next_s.reg_wdata = otp_rdata;
					if (s.reg_addr == scl_pkg::SER_CFG_ADDR)
					begin
						next_s.proto_i2c = ser[0];
						next_s.addr_a2   = ser[1];
					end
					next_s.pairs = s.pairs - 12'h001;
					if (s.pairs == 12'h001)
					begin
						next_s.cfg_loaded = 1'b1;
						next_s.st         = scl_pkg::ST_DONE;
					end
					else
						next_s.st = scl_pkg::ST_WADDR;
				end
			end
			scl_pkg::ST_EEP:
			begin
				if (!s.probe_busy)
				begin
					next_s.probe_start = 1'b1;
					next_s.probe_busy  = 1'b1;
				end
				else if (prb.done)
				begin
					next_s.probe_busy = 1'b0;
					if (!prb.found)
						next_s.cfg_error = scl_pkg::ERR_NOEEP;
					next_s.st = scl_pkg::ST_DONE;
				end
			end
			scl_pkg::ST_DONE:
			begin
				// Host writes only reach live registers; nothing feeds the memory
				next_s.load_done = 1'b1;
				if (host_wr && s.load_done && host_addr == scl_pkg::SER_CFG_ADDR)
				begin
					next_s.proto_i2c = ser[0];
					next_s.addr_a2   = ser[1];
				end
			end
			default:
				next_s.st = scl_pkg::ST_SYNC;
		endcase
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			s <= '0;
		else
			s <= next_s;
	end

	assign otp_rd      = s.otp_rd;
	assign otp_addr    = s.otp_addr;
	assign reg_clear   = s.reg_clear;
	assign reg_wr      = s.reg_wr;
	assign reg_addr    = s.reg_addr;
	assign reg_wdata   = s.reg_wdata;
	assign proto_i2c   = s.proto_i2c;
	assign addr_a2     = s.addr_a2;
	assign eeprom_en   = s.eeprom_en;
	assign cfg_index   = s.cfg_index;
	assign cfg_loaded  = s.cfg_loaded;
	assign cfg_error   = s.cfg_error;
	assign strap_fault = s.strap_fault;
	assign load_done   = s.load_done;
	assign eep_req     = prb.req;
	assign eep_addr    = prb.addr;
	assign eep_speed   = prb.speed;

	spi_no_a2_a: assert property (@(posedge mclk) disable iff (!rstn)
		!s.proto_i2c |-> !s.addr_a2)
		else $error("address bit set while SPI selected");
	clear_first_a: assert property (@(posedge mclk) disable iff (!rstn)
		(s.reg_wr || s.otp_rd) |-> s.seen_clear)
		else $error("memory activity before defaults applied");
	no_wr_done_a: assert property (@(posedge mclk) disable iff (!rstn)
		s.load_done |-> !s.reg_wr && !s.otp_rd && !s.probe_start)
		else $error("register write at or after completion");
	done_holds_a: assert property (@(posedge mclk) disable iff (!rstn)
		s.load_done |=> s.load_done && s.st == scl_pkg::ST_DONE)
		else $error("completion flag dropped");
	eep_gate_a: assert property (@(posedge mclk) disable iff (!rstn)
		s.probe_start |-> s.eeprom_en && !s.load_done)
		else $error("external memory probed while disabled");
	sum_bad_a: assert property (@(posedge mclk) disable iff (!rstn)
		(s.st == scl_pkg::ST_SUM && next_s.cfg_error == scl_pkg::ERR_SUM
		&& s.cfg_error != scl_pkg::ERR_SUM) |=> !s.reg_wr [*3] ##0 !s.cfg_loaded)
		else $error("bad checksum still wrote registers");
	capt_quiet_a: assert property (@(posedge mclk) disable iff (!rstn)
		s.st == scl_pkg::ST_SYNC |-> !s.reg_clear && !s.otp_rd && $stable(s.straps))
		else $error("activity before straps captured");
	default_idx_a: assert property (@(posedge mclk) disable iff (!rstn)
		(s.st == scl_pkg::ST_DECODE && s.fn == 32'h0000_0000)
		|=> s.cfg_index == {12'h000, $past(s.straps[3:0])})
		else $error("default index not taken from pins 3..0");
	loaded_ok_a: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(s.cfg_loaded) |-> s.cfg_error == scl_pkg::ERR_NONE && s.prog)
		else $error("configuration marked loaded after a failure");
endmodule

// file: verilog/scl_probe.sv
`timescale 1ns/1ns
module scl_probe (
	input  wire logic mclk,
	input  wire logic rstn,
	scl_prb_if.prb    p
);
	typedef struct packed {
		logic              busy;
		logic              wait_ans;
		logic              req;
		logic              done;
		logic              found;
		logic [6:0]        addr;
		scl_pkg::scl_spd_t speed;
	} scl_prb_state_t;

	scl_prb_state_t s;
	scl_prb_state_t next_s;

	// Walk every address at one speed, then drop to the next slower speed
	always_comb
	begin
		next_s      = s;
		next_s.req  = 1'b0;
		next_s.done = 1'b0;
		if (!s.busy && p.start)
		begin
			next_s.busy  = 1'b1;
			next_s.addr  = scl_pkg::EEP_ADDR_FIRST;
			next_s.speed = scl_pkg::SPD_1M;
			next_s.found = 1'b0;
		end
		else if (s.busy && !s.wait_ans)
		begin
			next_s.req      = 1'b1;
			next_s.wait_ans = 1'b1;
		end
		else if (s.busy && p.ack)
		begin
			next_s.busy     = 1'b0;
			next_s.wait_ans = 1'b0;
			next_s.found    = 1'b1;
			next_s.done     = 1'b1;
		end
		else if (s.busy && p.nak)
		begin
			next_s.wait_ans = 1'b0;
			if (s.addr != scl_pkg::EEP_ADDR_LAST)
				next_s.addr = s.addr + 7'h01;
			else if (s.speed == scl_pkg::SPD_100K)
			begin
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end
			else
			begin
				next_s.addr  = scl_pkg::EEP_ADDR_FIRST;
				next_s.speed = scl_pkg::scl_spd_t'(s.speed + 2'h1);
			end
		end
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			s <= '0;
		else
			s <= next_s;
	end

	assign p.req   = s.req;
	assign p.done  = s.done;
	assign p.found = s.found;
	assign p.addr  = s.addr;
	assign p.speed = s.speed;

	probe_range_a: assert property (@(posedge mclk) disable iff (!rstn)
		s.req |-> (s.addr >= scl_pkg::EEP_ADDR_FIRST && s.addr <= scl_pkg::EEP_ADDR_LAST))
		else $error("probe address outside the memory range");
endmodule

// file: verilog/scl_sync.sv
`timescale 1ns/1ns
module scl_sync (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [15:0] din,
	output logic [15:0]      dout
);
	typedef struct packed {
		logic [15:0] s1;
		logic [15:0] s2;
	} scl_sync_state_t;

	scl_sync_state_t s;
	scl_sync_state_t next_s;

	// Pins idle high through the pull-ups, so reset to ones
	always_comb
	begin
		next_s.s1 = din;
		next_s.s2 = s.s1;
	end

	always_ff @(posedge mclk or negedge rstn)
	begin
		if (!rstn)
			s <= '1;
		else
			s <= next_s;
	end

	assign dout = s.s2;
endmodule
